/* File: rtl/axh_pkg.sv */
// Shared constants and types for the axis homing sequencer
package axh_pkg;

    // ------------------------------------------------------------
    // Widths and configuration word layout
    // ------------------------------------------------------------
    localparam int          POS_W        = 32;
    localparam int          CFG_W        = 32;
    localparam int          CFG_NC_BIT   = 1;
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] CFG_WR_MASK  = 32'h0000_0002;

    // ------------------------------------------------------------
    // Homing modes
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_ACTIVE  = 2'h0;
    localparam logic [1:0]  MODE_PASSIVE = 2'h1;
    localparam logic [1:0]  MODE_ABS     = 2'h2;

    // ------------------------------------------------------------
    // Home sequence types
    // ------------------------------------------------------------
    localparam logic [1:0]  SEQ_IMM      = 2'h0;
    localparam logic [1:0]  SEQ_SW       = 2'h1;
    localparam logic [1:0]  SEQ_MK       = 2'h2;
    localparam logic [1:0]  SEQ_SWMK     = 2'h3;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_LEG1,
        ST_STOP1,
        ST_RET,
        ST_SEEK_MK,
        ST_STOP2,
        ST_PLAN,
        ST_EVAL,
        ST_UNWIND,
        ST_MOVE,
        ST_P_SW,
        ST_P_MK,
        ST_FIN
    } axh_state_t;

endpackage

/* File: rtl/axh_edge_sync.sv */
// Two-stage synchroniser with polarity-corrected edge detection
`timescale 1ns/1ps
`default_nettype none

module axh_edge_sync (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic pin,
    input  wire logic invert,
    output logic      active,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } axh_sync_t;

    axh_sync_t q;
    axh_sync_t d;
    logic      prev;

    always_comb begin
        d    = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Edges judged only after the second stage
    // ------------------------------------------------------------
    assign active = q.s2 ^ invert;
    assign prev   = q.s3 ^ invert;
    assign rise   = active & ~prev;
    assign fall   = ~active & prev;

endmodule
`default_nettype wire

/* File: rtl/axh_sequencer.sv */
// Homing sequencer for one servo axis
`timescale 1ns/1ps
`default_nettype none

module axh_sequencer
    import axh_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    input  wire logic                    cfg_wr,
    input  wire logic [axh_pkg::CFG_W-1:0] cfg_wdata,
    output logic [axh_pkg::CFG_W-1:0]    home_switch_config_word,
    input  wire logic                    homing_command,
    input  wire logic [1:0]              home_mode,
    input  wire logic [1:0]              home_seq,
    input  wire logic                    home_bidir,
    input  wire logic                    home_dir,
    input  wire logic                    axis_rotary,
    input  wire logic signed [axh_pkg::POS_W-1:0] home_position,
    input  wire logic signed [axh_pkg::POS_W-1:0] home_offset,
    input  wire logic [axh_pkg::POS_W-1:0] home_speed,
    input  wire logic [axh_pkg::POS_W-1:0] home_return_speed,
    input  wire logic [axh_pkg::POS_W-1:0] decel_dist,
    input  wire logic [axh_pkg::POS_W-1:0] rev_counts,
    input  wire logic signed [axh_pkg::POS_W-1:0] actual_pos,
    input  wire logic                    axis_stopped,
    input  wire logic                    move_done,
    input  wire logic                    home_switch_pin,
    input  wire logic                    marker_pin,
    output logic                         jog_run,
    output logic                         jog_dir,
    output logic [axh_pkg::POS_W-1:0]    jog_speed,
    output logic                         stop_req,
    output logic                         move_req,
    output logic signed [axh_pkg::POS_W-1:0] move_dist,
    output logic [axh_pkg::POS_W-1:0]    move_speed,
    output logic                         pos_load,
    output logic signed [axh_pkg::POS_W-1:0] pos_load_value,
    output logic                         abs_write,
    output logic signed [axh_pkg::POS_W-1:0] abs_value,
    output logic signed [axh_pkg::POS_W-1:0] home_ref_pos,
    output logic                         homing_in_progress_flag,
    output logic                         homing_done_flag
);
    import axh_pkg::*;

    typedef struct packed {
        axh_state_t               st;
        logic [CFG_W-1:0]         cfg;
        logic                     ip;
        logic                     done;
        logic                     jog;
        logic                     jdir;
        logic [POS_W-1:0]         jspd;
        logic                     stop;
        logic                     mreq;
        logic signed [POS_W-1:0]  mdist;
        logic [POS_W-1:0]         mspd;
        logic                     pload;
        logic signed [POS_W-1:0]  pval;
        logic                     awr;
        logic signed [POS_W-1:0]  aval;
        logic signed [POS_W-1:0]  ref_pos;
        logic signed [POS_W-1:0]  rem;
    } axh_regs_t;

    axh_regs_t q;
    axh_regs_t d;

    logic                    sw_act;
    logic                    sw_rise;
    logic                    sw_fall;
    logic                    mk_rise;
    logic signed [POS_W-1:0] doff;
    logic [POS_W-1:0]        off_mag;
    logic signed [POS_W-1:0] rem_dir;
    logic signed [POS_W-1:0] fin_val;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    axh_edge_sync u_sw_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin     (home_switch_pin),
        .invert  (q.cfg[CFG_NC_BIT]),
        .active  (sw_act),
        .rise    (sw_rise),
        .fall    (sw_fall)
    );

    axh_edge_sync u_mk_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin     (marker_pin),
        .invert  (1'b0),
        .active  (),
        .rise    (mk_rise),
        .fall    ()
    );

    // ------------------------------------------------------------
    // Offset arithmetic
    // ------------------------------------------------------------
    // Offset counts in the home direction.
    assign doff    = home_dir ? home_offset : -home_offset;
    assign off_mag = home_offset[POS_W-1] ? POS_W'(-home_offset)
                                          : POS_W'(home_offset);
    // Remaining travel measured along the home direction.
    assign rem_dir = home_dir ? q.rem : -q.rem;
    // Axis is at (event + offset) when this is loaded, so it reads home.
    assign fin_val = home_position + actual_pos - q.ref_pos - doff;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        d.stop  = 1'b0;
        d.mreq  = 1'b0;
        d.pload = 1'b0;
        d.awr   = 1'b0;
        if (cfg_wr) begin
            d.cfg = cfg_wdata & CFG_WR_MASK;
        end
        case (q.st)
            ST_IDLE: begin
                if (homing_command) begin
                    d.ip   = 1'b1;
                    d.done = 1'b0;
                    if (home_mode == MODE_ABS) begin
                        d.awr  = 1'b1;
                        d.aval = home_position;
                        d.ip   = 1'b0;
                        d.done = 1'b1;
                    end else if (home_seq == SEQ_IMM) begin
                        d.pload = 1'b1;
                        d.pval  = home_position;
                        d.ip    = 1'b0;
                        d.done  = 1'b1;
                    end else if (home_mode == MODE_PASSIVE) begin
                        // External agent moves the axis here.
                        d.st = (home_seq == SEQ_MK) ? ST_P_MK
                                                    : ST_P_SW;
                    end else if (home_seq == SEQ_SWMK) begin
                        d.jog = 1'b1;
                        if (home_bidir && sw_act) begin
                            d.jdir = ~home_dir;
                            d.jspd = home_return_speed;
                            d.st   = ST_RET;
                        end else begin
                            d.jdir = home_dir;
                            d.jspd = home_speed;
                            d.st   = ST_LEG1;
                        end
                    end else begin
                        // Other active sequences live elsewhere.
                        d.ip = 1'b0;
                    end
                end
            end
            ST_LEG1: begin
                if (sw_rise) begin
                    if (home_bidir) begin
                        d.jog  = 1'b0;
                        d.stop = 1'b1;
                        d.st   = ST_STOP1;
                    end else begin
                        d.st = ST_SEEK_MK;
                    end
                end
            end
            ST_STOP1: begin
                if (axis_stopped) begin
                    d.jog  = 1'b1;
                    d.jdir = ~home_dir;
                    d.jspd = home_return_speed;
                    d.st   = ST_RET;
                end
            end
            ST_RET: begin
                if (sw_fall) begin
                    d.st = ST_SEEK_MK;
                end
            end
            ST_SEEK_MK: begin
                if (mk_rise) begin
                    d.ref_pos = actual_pos;
                    d.jog     = 1'b0;
                    d.stop    = 1'b1;
                    d.st      = ST_STOP2;
                end
            end
            ST_STOP2: begin
                if (axis_stopped) begin
                    d.st = ST_PLAN;
                end
            end
            ST_PLAN: begin
                d.rem = q.ref_pos + doff - actual_pos;
                d.st  = ST_EVAL;
            end
            ST_EVAL: begin
                if (home_bidir) begin
                    d.mreq  = 1'b1;
                    d.mdist = q.rem;
                    d.mspd  = home_return_speed;
                    d.st    = ST_MOVE;
                end else if (!axis_rotary && off_mag < decel_dist) begin
                    // Stop only, flag ends without done.
                    d.ip = 1'b0;
                    d.st = ST_IDLE;
                end else if (rem_dir < 0) begin
                    d.st = ST_UNWIND;
                end else begin
                    d.mreq  = 1'b1;
                    d.mdist = q.rem;
                    d.mspd  = home_speed;
                    d.st    = ST_MOVE;
                end
            end
            ST_UNWIND: begin
                // One revolution per UNWIND/EVAL pass, every two cycles, until the move is forward.
                d.rem = home_dir ? q.rem + $signed(rev_counts)
                                 : q.rem - $signed(rev_counts);
                d.st  = ST_EVAL;
            end
            ST_MOVE: begin
                if (move_done) begin
                    d.st = ST_FIN;
                end
            end
            ST_P_SW: begin
                if (sw_rise) begin
                    d.ref_pos = actual_pos;
                    d.st = (home_seq == SEQ_SWMK) ? ST_P_MK
                                                  : ST_FIN;
                end
            end
            ST_P_MK: begin
                if (mk_rise) begin
                    d.ref_pos = actual_pos;
                    d.st      = ST_FIN;
                end
            end
            ST_FIN: begin
                d.pload = 1'b1;
                d.pval  = fin_val;
                d.ip    = 1'b0;
                d.done  = 1'b1;
                d.st    = ST_IDLE;
            end
            default: begin
                d.st  = ST_IDLE;
                d.jog = 1'b0;
                d.ip  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q      <= '0;
            q.st   <= ST_IDLE;
            q.cfg  <= CFG_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign home_switch_config_word = q.cfg;
    assign jog_run                 = q.jog;
    assign jog_dir                 = q.jdir;
    assign jog_speed               = q.jspd;
    assign stop_req                = q.stop;
    assign move_req                = q.mreq;
    assign move_dist               = q.mdist;
    assign move_speed              = q.mspd;
    assign pos_load                = q.pload;
    assign pos_load_value          = q.pval;
    assign abs_write               = q.awr;
    assign abs_value               = q.aval;
    assign home_ref_pos            = q.ref_pos;
    assign homing_in_progress_flag = q.ip;
    assign homing_done_flag        = q.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_leg1;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_LEG1 |-> jog_run && jog_dir == home_dir
                            && jog_speed == home_speed;
    endproperty
    a_leg1: assert property (p_leg1)
        else $error("first leg direction or speed wrong");

    property p_mk_latch;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_SEEK_MK && mk_rise |=>
            home_ref_pos == $past(actual_pos) && stop_req && !jog_run;
    endproperty
    a_mk_latch: assert property (p_mk_latch)
        else $error("marker position not latched with stop");

    property p_short;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_EVAL && !home_bidir && !axis_rotary
            && off_mag < decel_dist |=>
            !homing_in_progress_flag && !homing_done_flag && !move_req;
    endproperty
    a_short: assert property (p_short)
        else $error("short offset case not ended correctly");

    property p_imm;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_IDLE && homing_command && home_mode != MODE_ABS
            && home_seq == SEQ_IMM |=>
            pos_load && pos_load_value == $past(home_position)
            && !jog_run && homing_done_flag;
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate homing did not load home position");

    property p_abs;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_IDLE && homing_command && home_mode == MODE_ABS |=>
            abs_write && abs_value == $past(home_position);
    endproperty
    a_abs: assert property (p_abs)
        else $error("absolute write missing");

    property p_passive;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_P_SW || q.st == ST_P_MK |-> !jog_run && !move_req;
    endproperty
    a_passive: assert property (p_passive)
        else $error("passive homing commanded motion");

    property p_arm;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_P_SW && !sw_rise |=> home_ref_pos == $past(home_ref_pos);
    endproperty
    a_arm: assert property (p_arm)
        else $error("reference taken before switch event");

    property p_ret;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_RET |-> jog_speed == home_return_speed
                           && jog_dir != home_dir;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return leg speed or direction wrong");

    property p_start_rev;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_IDLE && homing_command && home_mode == MODE_ACTIVE
            && home_seq == SEQ_SWMK && home_bidir && sw_act |=>
            q.st == ST_RET;
    endproperty
    a_start_rev: assert property (p_start_rev)
        else $error("active switch at start did not reverse");

    property p_fwd;
        @(posedge ref_clk) disable iff (srst)
        move_req && !home_bidir |->
            (home_dir ? move_dist >= 0 : move_dist <= 0);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("uni-directional move would reverse");

    property p_fin;
        @(posedge ref_clk) disable iff (srst)
        q.st == ST_FIN |=> pos_load && homing_done_flag
            && !homing_in_progress_flag
            ##1 $past(pos_load_value) == pos_load_value;
    endproperty
    a_fin: assert property (p_fin)
        else $error("completion did not redefine position");

    property p_cfg;
        @(posedge ref_clk) disable iff (srst)
        cfg_wr |=> home_switch_config_word
            == ($past(cfg_wdata) & CFG_WR_MASK);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("reserved config bits not masked");

endmodule
`default_nettype wire

/* File: dv/axh_axis_model.sv */
// Behavioural axis drive with home switch and encoder marker
`timescale 1ns/1ps
`default_nettype none
module axh_axis_model
    import axh_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire logic                          jog_run,
    input  wire logic                          jog_dir,
    input  wire logic [axh_pkg::POS_W-1:0]     jog_speed,
    input  wire logic                          stop_req,
    input  wire logic                          move_req,
    input  wire logic signed [axh_pkg::POS_W-1:0] move_dist,
    input  wire logic                          pos_load,
    input  wire logic signed [axh_pkg::POS_W-1:0] pos_load_value,
    input  wire logic                          nc,
    input  wire logic signed [axh_pkg::POS_W-1:0] ext_step,
    output logic signed [axh_pkg::POS_W-1:0]   actual_pos,
    output logic signed [axh_pkg::POS_W-1:0]   sw_at,
    output logic signed [axh_pkg::POS_W-1:0]   mk_at,
    output logic                               axis_stopped,
    output logic                               move_done,
    output logic                               home_switch_pin,
    output logic                               marker_pin
);
    import axh_pkg::*;
    logic signed [POS_W-1:0] pos_q, mv_d_q;
    logic [POS_W-1:0]        spd_q;
    logic                    dir_q, mk_q, sw_q;
    int                      dec_q, mv_q;
    // ----------------------------------------
    // Switch at 300 counts, marker every 128
    // ----------------------------------------
    assign actual_pos      = pos_q;
    assign home_switch_pin = (pos_q >= 300) ^ nc;
    assign marker_pin      = (pos_q[6:0] < 7'h04);
    // A pending stop request means the drive has not begun braking yet
    assign axis_stopped    = !jog_run && !stop_req && dec_q == 0
                             && mv_q == 0;
    always_ff @(posedge ref_clk) begin
        move_done <= 1'b0;
        // Position redefinition is not a marker crossing
        mk_q <= marker_pin || pos_load;
        sw_q <= pos_q >= 300;
        if (marker_pin && !mk_q)
            mk_at <= pos_q;
        if (pos_q >= 300 && !sw_q)
            sw_at <= pos_q;
        if (jog_run) begin
            dir_q <= jog_dir;
            spd_q <= jog_speed;
        end
        // Stop takes a few cycles, so the drive overshoots
        dec_q <= stop_req ? 4 : (dec_q > 0 ? dec_q - 1 : 0);
        if (move_req) begin
            mv_q <= 5;
            mv_d_q <= move_dist;
        end else if (mv_q > 0)
            mv_q <= mv_q - 1;
        if (pos_load)
            pos_q <= pos_load_value;
        else if (mv_q == 1) begin
            pos_q <= pos_q + mv_d_q;
            move_done <= 1'b1;
        end else if (jog_run)
            pos_q <= jog_dir ? pos_q + jog_speed : pos_q - jog_speed;
        else if (dec_q > 0)
            pos_q <= dir_q ? pos_q + spd_q : pos_q - spd_q;
        else
            pos_q <= pos_q + ext_step;
        if (srst) begin
            pos_q <= 32'h0;
            dec_q <= 0;
            mv_q <= 0;
        end
    end
endmodule
`default_nettype wire

/* File: dv/axh_sequencer_tb.sv */
// Self-checking bench for the axis homing sequencer
`timescale 1ns/1ps
`default_nettype none
module axh_sequencer_tb;
    import axh_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, nc = 1'b1;
    logic homing_command = 1'b0, home_bidir = 1'b0, home_dir = 1'b1;
    logic axis_rotary = 1'b0;
    logic [1:0] home_mode = 2'h0, home_seq = 2'h0;
    logic [POS_W-1:0] cfg_wdata = 32'h0, home_speed = 32'h2;
    logic [POS_W-1:0] home_return_speed = 32'h1, decel_dist = 32'hA;
    logic [POS_W-1:0] rev_counts = 32'h80, jog_speed, move_speed, mv_s;
    logic signed [POS_W-1:0] home_position = 32'h0, home_offset = 32'h0;
    logic signed [POS_W-1:0] ext_step = 32'h0, move_dist, pos_load_value;
    logic signed [POS_W-1:0] abs_value, home_ref_pos, actual_pos, sw_at;
    logic signed [POS_W-1:0] mk_at, mv_d, mv_a, pl_v, ab_v, d;
    logic [CFG_W-1:0] home_switch_config_word;
    logic jog_run, jog_dir, stop_req, move_req, pos_load, abs_write;
    logic axis_stopped, move_done, home_switch_pin, marker_pin;
    logic homing_in_progress_flag, homing_done_flag;
    int fails = 0, compares = 0, cyc = 0, mv_cnt = 0, jog_cnt = 0;

    axh_sequencer  dut (.*);
    axh_axis_model axis (.*);

    always #5 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Pulse capture and hang guard
    // ----------------------------------------
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (jog_run)
            jog_cnt = jog_cnt + 1;
        if (move_req) begin
            mv_cnt = mv_cnt + 1;
            mv_d <= move_dist;
            mv_a <= actual_pos;
            mv_s <= move_speed;
        end
        if (pos_load)
            pl_v <= pos_load_value;
        if (abs_write)
            ab_v <= abs_value;
        if (cyc == 20000) begin
            fails = fails + 1;
            $display("[ERR] %0t timeout", $time);
            print_verdict;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cfgw(input logic [31:0] v);
        @(posedge ref_clk);
        cfg_wr <= 1'b1;
        cfg_wdata <= v;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic run(input logic [1:0] md, input logic [1:0] sq,
                       input int hp, input int st, input int off,
                       input int dec, input logic rot);
        @(posedge ref_clk);
        home_mode <= md;
        home_seq <= sq;
        home_position <= hp;
        ext_step <= st;
        home_offset <= off;
        decel_dist <= dec;
        axis_rotary <= rot;
        homing_command <= 1'b1;
        mv_cnt = 0;
        jog_cnt = 0;
        @(posedge ref_clk);
        homing_command <= 1'b0;
        @(negedge ref_clk);
    endtask
    // External motion stops once the sequence is over
    task automatic wait_end;
        for (int n = 0; n < 3000 && homing_in_progress_flag !== 1'b0; n++)
            @(negedge ref_clk);
        chk(homing_in_progress_flag, 32'h0, "ip stuck");
        @(posedge ref_clk);
        ext_step <= 32'h0;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic home0;
        run(MODE_PASSIVE, SEQ_IMM, 0, 0, 500, 10, 1'b0);
        wait_end;
        chk(pl_v, 32'h0, "imm value");
        chk(homing_done_flag, 32'h1, "imm done");
        chk(jog_cnt + mv_cnt, 32'h0, "imm motion");
    endtask
    task automatic print_verdict;
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        cfgw(32'hFFFFFFFF);
        chk(home_switch_config_word, 32'h2, "cfg");
        home0;
        run(MODE_PASSIVE, SEQ_SW, 0, 2, 0, 10, 1'b0);
        wait_end;
        chk(home_ref_pos, sw_at + 4, "nc ref");
        chk(jog_cnt + mv_cnt, 32'h0, "passive motion");
        cfgw(32'h0);
        @(posedge ref_clk);
        nc <= 1'b0;
        home0;
        run(MODE_PASSIVE, SEQ_SWMK, 0, 2, 0, 10, 1'b0);
        wait_end;
        chk(home_ref_pos, mk_at + 4, "swmk ref");
        run(MODE_ABS, SEQ_SW, 77, 0, 0, 10, 1'b0);
        wait_end;
        chk(ab_v, 32'd77, "abs");
        home0;
        run(MODE_ACTIVE, SEQ_SWMK, 0, 0, 500, 10, 1'b0);
        chk(jog_run, 32'h1, "jog");
        chk(jog_dir, 32'h1, "dir");
        chk(jog_speed, 32'h2, "speed");
        wait_end;
        chk(home_ref_pos, mk_at + 4, "ref");
        chk(mv_d, mk_at + 504 - mv_a, "dist");
        chk(mv_s, 32'h2, "move speed");
        chk(pl_v, 32'h0, "final");
        chk(homing_done_flag, 32'h1, "done");
        home0;
        @(posedge ref_clk);
        home_bidir <= 1'b1;
        run(MODE_ACTIVE, SEQ_SWMK, 0, 0, 500, 10, 1'b0);
        wait_end;
        chk(home_ref_pos, mk_at - 2, "bidir ref");
        chk(mv_s, 32'h1, "return speed");
        chk(pl_v, 32'h0, "bidir final");
        @(posedge ref_clk);
        home_bidir <= 1'b0;
        home0;
        run(MODE_ACTIVE, SEQ_SWMK, 0, 0, 50, 1000, 1'b0);
        wait_end;
        chk(homing_done_flag, 32'h0, "short done");
        chk(mv_cnt, 32'h0, "short move");
        home0;
        run(MODE_ACTIVE, SEQ_SWMK, 10, 0, 5, 20, 1'b1);
        wait_end;
        d = mv_d - (mk_at + 9 - mv_a);
        chk(d[6:0] == 0 && d > 0 && mv_d > 0, 32'h1, "rev");
        print_verdict;
    end
endmodule
`default_nettype wire
